// [rtl/ext_irq_consts.vh]
// constants for the external interrupt and vector block
// assumes inclusion by bare name from the rtl files
`ifndef EXT_IRQ_CONSTS_VH
`define EXT_IRQ_CONSTS_VH

// register byte offsets
`define OFF_EXT_IRQ_STATUS_CONTROL 4'h0
`define OFF_CORE_STATUS            4'h4
`define ADDR_W                     4

// external_irq_status_control field positions
`define BIT_PIN_IRQ_ENABLE   7
`define BIT_PORT_IRQ_ENABLE  6
`define BIT_PIN_IRQ_PENDING  3
`define BIT_PORT_IRQ_PENDING 2
`define BIT_IRQ_ACKNOWLEDGE  1

// core status field positions
`define BIT_STAT_IMASK    0
`define BIT_STAT_IRQREQ   1
`define BIT_STAT_PINLEVEL 2
`define BIT_STAT_VEC_LO   16

// reset values
`define RST_PIN_IRQ_ENABLE  1'b1
`define RST_PORT_IRQ_ENABLE 1'b0
`define RST_IMASK           1'b1

// vector pair base addresses, high to low priority
`define VEC_EXTERNAL 16'h3FFA
`define VEC_TIMER16  16'h3FF8
`define VEC_SERIAL   16'h3FF6
`define VEC_SPI      16'h3FF4
`define VEC_CORETMR  16'h3FF2
`define VEC_GAUGE    16'h3FF0
`define VEC_NONE     16'h0000

// request index order into the vector selector
`define REQ_EXTERNAL 5
`define REQ_TIMER16  4
`define REQ_SERIAL   3
`define REQ_SPI      2
`define REQ_CORETMR  1
`define REQ_GAUGE    0
`define REQ_N        6

// axi responses
`define RESP_OKAY   2'h0
`define RESP_SLVERR 2'h2

`endif

// [rtl/external_irq_ctrl.v]
// external interrupt flags, interrupt mask, vector choice and reset pin
// assumes an axi4-lite master on clk and a cpu core that pulses vecFetch
// Notes on behaviour
// - software writes to the pin pending flag are ignored.
// - fetching the external vector clears the pin pending flag.
// - writing one to acknowledge clears the pin pending flag.
// - pin pending plus its enable keeps the external request up.
// - pin pending flag sets only while pin enable is set.
// - reset clears the pin pending flag.
// - port pending ignores writes and vector fetch; acknowledge clears it.
// - port pending plus its enable keeps the external request up.
// - port pending latches events whatever port enable says.
// - reset clears the port pending flag.
// - acknowledge one clears both flags; zero changes nothing.
// - falling edge is synchronised, latched, served at 3FFA/3FFB.
// - interrupt mask set blocks every maskable request.
// - pin trigger is edge only or edge plus low level, at build.
// - any enabled 16-bit timer flag raises one request at 3FF8/3FF9.
// - serial link request vectors at 3FF6/3FF7.
// - either enabled spi flag raises one request at 3FF4/3FF5.
// - 8-bit timer requests on enabled overflow or enabled period.
// - core timer request vectors at 3FF2/3FF3.
// - gauge synchronise request vectors at 3FF0/3FF1.
// - stop or wait entry clears the mask; port events still recognised.
// - low reset pin holds internal reset until it rises again.
// - reset sets pin enable, clears port enable; stop/wait sets pin enable.
// - acknowledge and unused bits read as zero.
`timescale 1ns/1ps
`include "ext_irq_consts.vh"
module external_irq_ctrl #(
  parameter LEVEL_TRIG = 0
) (
  input  wire                clk,
  input  wire                rst,
  input  wire                ce,
  // axi4-lite slave
  input  wire [`ADDR_W-1:0]  s_axi_awaddr,
  input  wire                s_axi_awvalid,
  output reg                 s_axi_awready,
  input  wire [31:0]         s_axi_wdata,
  input  wire [3:0]          s_axi_wstrb,
  input  wire                s_axi_wvalid,
  output reg                 s_axi_wready,
  output reg  [1:0]          s_axi_bresp,
  output reg                 s_axi_bvalid,
  input  wire                s_axi_bready,
  input  wire [`ADDR_W-1:0]  s_axi_araddr,
  input  wire                s_axi_arvalid,
  output reg                 s_axi_arready,
  output reg  [31:0]         s_axi_rdata,
  output reg  [1:0]          s_axi_rresp,
  output reg                 s_axi_rvalid,
  input  wire                s_axi_rready,
  // pins, asynchronous
  input  wire                irqPinN,
  input  wire [7:0]          portPin,
  input  wire                resetPinN,
  // port configuration from port logic, same clock
  input  wire [7:0]          portDirOut,
  input  wire [7:0]          portDataOut,
  // peripheral flags and enables, same clock
  input  wire [2:0]          timerStatusFlags,
  input  wire [2:0]          timerControlEnables,
  input  wire                serialLinkIrq,
  input  wire [1:0]          serialPeriphStatusFlags,
  input  wire [1:0]          serialPeriphControlEnables,
  input  wire                coreTimerOverflow,
  input  wire                coreTimerOverflowEnable,
  input  wire                periodicFlag,
  input  wire                periodicInterruptEnable,
  input  wire                gaugeSyncIrq,
  // cpu core, same clock, one-cycle pulses
  input  wire                vecFetch,
  input  wire                setIMask,
  input  wire                clearIMask,
  input  wire                stopWaitEnter,
  output reg                 irqRequest,
  output reg  [15:0]         vectorAddr,
  output reg                 iMask,
  output reg                 sysReset
);
  wire       irqPinSync;
  wire [7:0] portPinSync;
  wire       resetPinSync;

  sync_2ff #(.WIDTH(1), .INIT(1'b1)) uIrqSync (
    .clk (clk),
    .rst (rst),
    .ce  (ce),
    .d   (irqPinN),
    .q   (irqPinSync)
  );

  sync_2ff #(.WIDTH(8), .INIT(8'hFF)) uPortSync (
    .clk (clk),
    .rst (rst),
    .ce  (ce),
    .d   (portPin),
    .q   (portPinSync)
  );

  sync_2ff #(.WIDTH(1), .INIT(1'b1)) uResetSync (
    .clk (clk),
    .rst (rst),
    .ce  (ce),
    .d   (resetPinN),
    .q   (resetPinSync)
  );

  // syncs stay on rst alone, so a low reset pin can still be seen rising
  // pin reset acts like rst on the edge, flag, enable, mask and request registers; the bus side and sysReset stay on rst
  wire localRst = rst | ~resetPinSync;

  always @(posedge clk) begin
    if (rst)
      sysReset <= 1'b1;
    else if (ce)
      sysReset <= ~resetPinSync;
  end

  // pin and port edge detection
  // reset to the idle high level so reset itself never looks like an edge
  reg pinPrev_r;
  reg portPrev_r;

  // a pin set as output or with its data bit high never makes an edge
  wire portAnd = &(portPinSync | portDirOut | portDataOut);

  always @(posedge clk) begin
    if (localRst) begin
      pinPrev_r  <= 1'b1;
      portPrev_r <= 1'b1;
    end else if (ce) begin
      pinPrev_r  <= irqPinSync;
      portPrev_r <= portAnd;
    end
  end

  wire pinFall  = pinPrev_r & ~irqPinSync;
  wire portFall = portPrev_r & ~portAnd;

  // level mode keeps setting the flag while the pin stays low
  wire pinEvent = (LEVEL_TRIG != 0) ? (pinFall | ~irqPinSync) : pinFall;

  // status and control register
  reg pinIrqEnable_r;
  reg portIrqEnable_r;
  reg pinIrqPending_r;
  reg portIrqPending_r;
  reg pinIrqEnable_nxt;
  reg portIrqEnable_nxt;
  reg pinIrqPending_nxt;
  reg portIrqPending_nxt;

  // axi write side
  // address and data are taken in either order and held until the response
  // pin reset leaves the bus alone so a transfer in flight still completes
  reg [`ADDR_W-1:0] awAddr_r;
  reg               awHeld_r;
  reg [31:0]        wData_r;
  reg [3:0]         wStrb_r;
  reg               wHeld_r;

  wire awTake   = s_axi_awvalid & s_axi_awready;
  wire wTake    = s_axi_wvalid & s_axi_wready;
  wire wrFire   = awHeld_r & wHeld_r & ~s_axi_bvalid;
  wire wrCtl    = wrFire & (awAddr_r == `OFF_EXT_IRQ_STATUS_CONTROL);
  wire wrMapped = (awAddr_r == `OFF_EXT_IRQ_STATUS_CONTROL) |
                  (awAddr_r == `OFF_CORE_STATUS);
  wire wrLane0  = wrCtl & wStrb_r[0];
  wire ackWrite = wrLane0 & wData_r[`BIT_IRQ_ACKNOWLEDGE];

  always @(posedge clk) begin
    if (rst) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `RESP_OKAY;
      awAddr_r      <= {`ADDR_W{1'b0}};
      awHeld_r      <= 1'b0;
      wData_r       <= 32'h00000000;
      wStrb_r       <= 4'h0;
      wHeld_r       <= 1'b0;
    end else if (ce) begin
      if (awTake) begin
        awAddr_r      <= s_axi_awaddr;
        awHeld_r      <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (wTake) begin
        wData_r      <= s_axi_wdata;
        wStrb_r      <= s_axi_wstrb;
        wHeld_r      <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (wrFire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wrMapped ? `RESP_OKAY : `RESP_SLVERR;
      end
      if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        awHeld_r      <= 1'b0;
        wHeld_r       <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // flag and enable next values; sets win over clears
  // an enable written with an event in one cycle: the set uses the old enable
  always @* begin
    pinIrqEnable_nxt   = pinIrqEnable_r;
    portIrqEnable_nxt  = portIrqEnable_r;
    pinIrqPending_nxt  = pinIrqPending_r;
    portIrqPending_nxt = portIrqPending_r;
    if (wrLane0) begin
      pinIrqEnable_nxt  = wData_r[`BIT_PIN_IRQ_ENABLE];
      portIrqEnable_nxt = wData_r[`BIT_PORT_IRQ_ENABLE];
      // pending bits in wData_r are not looked at
    end
    if (ackWrite) begin
      pinIrqPending_nxt  = 1'b0;
      portIrqPending_nxt = 1'b0;
    end
    if (vecFetch && vectorAddr == `VEC_EXTERNAL)
      pinIrqPending_nxt = 1'b0;
    if (stopWaitEnter)
      pinIrqEnable_nxt = 1'b1;
    if (pinEvent && pinIrqEnable_r)
      pinIrqPending_nxt = 1'b1;
    if (portFall)
      portIrqPending_nxt = 1'b1;
  end

  always @(posedge clk) begin
    if (localRst) begin
      pinIrqEnable_r   <= `RST_PIN_IRQ_ENABLE;
      portIrqEnable_r  <= `RST_PORT_IRQ_ENABLE;
      pinIrqPending_r  <= 1'b0;
      portIrqPending_r <= 1'b0;
    end else if (ce) begin
      pinIrqEnable_r   <= pinIrqEnable_nxt;
      portIrqEnable_r  <= portIrqEnable_nxt;
      pinIrqPending_r  <= pinIrqPending_nxt;
      portIrqPending_r <= portIrqPending_nxt;
    end
  end

  // interrupt mask; vector fetch masks further entry
  // stop or wait entry wins over a set in the same cycle
  always @(posedge clk) begin
    if (localRst)
      iMask <= `RST_IMASK;
    else if (ce) begin
      if (stopWaitEnter)
        iMask <= 1'b0;
      else if (setIMask | vecFetch)
        iMask <= 1'b1;
      else if (clearIMask)
        iMask <= 1'b0;
    end
  end

  // source requests
  // the vector follows the winner even while masked; irqRequest carries the mask
  wire [`REQ_N-1:0] reqVec;
  wire [15:0]       selVector;
  wire              anyReq;

  // level requests re-enter until flag or enable drops
  assign reqVec[`REQ_EXTERNAL] = (pinIrqPending_r & pinIrqEnable_r) |
                                 (portIrqPending_r & portIrqEnable_r);
  assign reqVec[`REQ_TIMER16]  = |(timerStatusFlags & timerControlEnables);
  assign reqVec[`REQ_SERIAL]   = serialLinkIrq;
  assign reqVec[`REQ_SPI]      = |(serialPeriphStatusFlags &
                                   serialPeriphControlEnables);
  assign reqVec[`REQ_CORETMR]  = (coreTimerOverflow & coreTimerOverflowEnable) |
                                 (periodicFlag & periodicInterruptEnable);
  assign reqVec[`REQ_GAUGE]    = gaugeSyncIrq;

  irq_vector_select uSelect (
    .req    (reqVec),
    .vector (selVector),
    .any    (anyReq)
  );

  // port events stay live in stop/wait since only ce freezes this logic
  always @(posedge clk) begin
    if (localRst) begin
      irqRequest <= 1'b0;
      vectorAddr <= `VEC_NONE;
    end else if (ce) begin
      irqRequest <= anyReq & ~iMask & ~vecFetch;
      vectorAddr <= selVector;
    end
  end

  // axi read side
  // one read in flight; arready returns only after the r handshake
  wire        arTake = s_axi_arvalid & s_axi_arready;
  reg  [31:0] readMux;
  reg         readHit;

  always @* begin
    readMux = 32'h00000000;
    readHit = 1'b1;
    case (s_axi_araddr)
      `OFF_EXT_IRQ_STATUS_CONTROL: begin
        // acknowledge and unused bits stay zero
        readMux[`BIT_PIN_IRQ_ENABLE]   = pinIrqEnable_r;
        readMux[`BIT_PORT_IRQ_ENABLE]  = portIrqEnable_r;
        readMux[`BIT_PIN_IRQ_PENDING]  = pinIrqPending_r;
        readMux[`BIT_PORT_IRQ_PENDING] = portIrqPending_r;
      end
      `OFF_CORE_STATUS: begin
        readMux[`BIT_STAT_IMASK]    = iMask;
        readMux[`BIT_STAT_IRQREQ]   = irqRequest;
        readMux[`BIT_STAT_PINLEVEL] = irqPinSync;
        readMux[`BIT_STAT_VEC_LO +: 16] = vectorAddr;
      end
      default: readHit = 1'b0;
    endcase
  end

  always @(posedge clk) begin
    if (rst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `RESP_OKAY;
    end else if (ce) begin
      if (arTake) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= readMux;
        s_axi_rresp   <= readHit ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_rvalid & s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end
endmodule

// [rtl/irq_vector_select.v]
// fixed-priority vector selector for the maskable sources
// assumes req bits ordered as the REQ_ defines
`timescale 1ns/1ps
`include "ext_irq_consts.vh"
module irq_vector_select (
  input  wire [`REQ_N-1:0] req,
  output reg  [15:0]       vector,
  output wire              any
);
  assign any = |req;

  always @* begin
    vector = `VEC_NONE;
    if (req[`REQ_EXTERNAL])
      vector = `VEC_EXTERNAL;
    else if (req[`REQ_TIMER16])
      vector = `VEC_TIMER16;
    else if (req[`REQ_SERIAL])
      vector = `VEC_SERIAL;
    else if (req[`REQ_SPI])
      vector = `VEC_SPI;
    else if (req[`REQ_CORETMR])
      vector = `VEC_CORETMR;
    else if (req[`REQ_GAUGE])
      vector = `VEC_GAUGE;
  end
endmodule

// [rtl/sync_2ff.v]
// two-flop synchroniser for pins from outside the clock domain
// assumes a free-running clk; idle value set by INIT
`timescale 1ns/1ps
module sync_2ff #(
  parameter             WIDTH = 1,
  parameter [WIDTH-1:0] INIT  = {WIDTH{1'b1}}
) (
  input  wire             clk,
  input  wire             rst,
  input  wire             ce,
  input  wire [WIDTH-1:0] d,
  output reg  [WIDTH-1:0] q
);
  reg [WIDTH-1:0] meta_r;

  // meta_r feeds only q
  always @(posedge clk) begin
    if (rst) begin
      meta_r <= INIT;
      q      <= INIT;
    end else if (ce) begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule

// [test/cpu_model.sv]
// cpu core stand-in: fetches the offered vector after a chosen lag
// assumes the same clock as the block; fetch is a one-cycle pulse
`timescale 1ns/1ps
module cpu_model (
  input  wire        clk,
  input  wire        rst,
  input  wire        irqRequest,
  input  wire [15:0] vectorAddr,
  input  wire        autoFetch,
  input  wire [3:0]  lag,
  output reg         vecFetch,
  output reg  [15:0] fetchedVec,
  output reg  [7:0]  fetchCount
);
  reg [3:0] waitCnt;
  // no second pulse while the first is still landing
  always @(posedge clk) begin
    vecFetch <= !rst && autoFetch && irqRequest && !vecFetch && waitCnt == lag;
    if (rst) begin
      waitCnt <= 4'h0;
      fetchCount <= 8'h00;
      fetchedVec <= 16'h0000;
    end else if (autoFetch && irqRequest && !vecFetch) begin
      if (waitCnt == lag) begin
        fetchedVec <= vectorAddr;
        fetchCount <= fetchCount + 8'h01;
        waitCnt <= 4'h0;
      end else begin
        waitCnt <= waitCnt + 4'h1;
      end
    end else begin
      waitCnt <= 4'h0;
    end
  end
endmodule

// [test/external_irq_ctrl_assertions.sv]
// port checker for the external interrupt block
// assumes it is bound onto every external_irq_ctrl instance
`timescale 1ns/1ps
module external_irq_ctrl_assertions (
  input wire        clk,
  input wire        rst,
  input wire        vecFetch,
  input wire        setIMask,
  input wire        clearIMask,
  input wire        stopWaitEnter,
  input wire        resetPinN,
  input wire        irqRequest,
  input wire [15:0] vectorAddr,
  input wire        iMask,
  input wire        sysReset
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // reset must not be disabled by itself
  property p_rst;
    disable iff (1'b0) rst |=> iMask && !irqRequest && sysReset;
  endproperty
  a_rst: assert property (p_rst) else $error("reset outputs wrong");
  property p_mask;
    $past(iMask) && iMask |-> !irqRequest;
  endproperty
  a_mask: assert property (p_mask) else $error("request while masked");
  property p_fetch;
    vecFetch && irqRequest |=> !irqRequest && iMask;
  endproperty
  a_fetch: assert property (p_fetch) else $error("fetch did not end request");
  property p_set;
    setIMask && !stopWaitEnter |=> iMask;
  endproperty
  a_set: assert property (p_set) else $error("mask not set");
  property p_clr;
    clearIMask && !setIMask && !vecFetch && !stopWaitEnter |=> !iMask;
  endproperty
  a_clr: assert property (p_clr) else $error("mask not cleared");
  property p_stop;
    stopWaitEnter |=> !iMask;
  endproperty
  a_stop: assert property (p_stop) else $error("stop entry kept mask");
  property p_vec;
    vectorAddr == 16'h0000 || (vectorAddr[15:4] == 12'h3FF && !vectorAddr[0]
      && vectorAddr[3:0] <= 4'hA);
  endproperty
  a_vec: assert property (p_vec) else $error("vector outside table");
  property p_rdown;
    !resetPinN [*5] |-> sysReset;
  endproperty
  a_rdown: assert property (p_rdown) else $error("pin reset not applied");
  property p_rup;
    (resetPinN && !rst) [*6] |-> !sysReset;
  endproperty
  a_rup: assert property (p_rup) else $error("pin reset not released");
  c_ext: cover property (irqRequest && vectorAddr == 16'h3FFA);
  c_rpin: cover property ($rose(sysReset));
  c_stop: cover property (stopWaitEnter);
endmodule
bind external_irq_ctrl external_irq_ctrl_assertions chk (.clk, .rst, .vecFetch, .setIMask,
  .clearIMask, .stopWaitEnter, .resetPinN, .irqRequest, .vectorAddr, .iMask, .sysReset);

// [test/tb_top.sv]
// self-checking bench for the external interrupt block
// assumes cpu_model as the core and the bound checker
`timescale 1ns/1ps
`define CHK(n, e, g) begin totalChecks = totalChecks + 1; if ((g) !== (e)) begin errors = errors + 1; $display("ERROR %s exp %0h got %0h", n, e, g); end end
module tb_top;
  reg         clk = 1'b0;
  reg         rst = 1'b1;
  reg  [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF, lag = 4'h0;
  reg  [31:0] s_axi_wdata = 32'h0, rd;
  reg         s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  reg         s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, autoFetch = 1'b0;
  reg         irqPinN = 1'b1, resetPinN = 1'b1;
  reg         setIMask = 1'b0, clearIMask = 1'b0, stopWaitEnter = 1'b0;
  reg  [7:0]  portPin = 8'hFF, c;
  reg  [15:0] per = 16'h0;
  reg  [1:0]  rsp;
  wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire        irqRequest, iMask, sysReset, vecFetch;
  wire [1:0]  s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [15:0] vectorAddr, fetchedVec, lvlVector;
  wire [7:0]  fetchCount;
  integer     errors = 0, totalChecks = 0, i;
  // peripheral request sources and the expected vector, pairwise
  localparam [143:0] TV = {16'h9000, 16'h8000, 16'h0200, 16'h00A0, 16'h0018,
    16'h0006, 16'h0010, 16'h0001, 16'h9201};
  localparam [143:0] EV = {16'h3FF8, 16'h0000, 16'h3FF6, 16'h3FF4, 16'h3FF2,
    16'h3FF2, 16'h0000, 16'h3FF0, 16'h3FF8};
  external_irq_ctrl #(.LEVEL_TRIG(0)) DUT (.clk, .rst, .ce(1'b1), .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irqPinN, .portPin, .resetPinN,
    .portDirOut(8'h00), .portDataOut(8'h00), .timerStatusFlags(per[15:13]),
    .timerControlEnables(per[12:10]), .serialLinkIrq(per[9]),
    .serialPeriphStatusFlags(per[8:7]), .serialPeriphControlEnables(per[6:5]),
    .coreTimerOverflow(per[4]), .coreTimerOverflowEnable(per[3]), .periodicFlag(per[2]),
    .periodicInterruptEnable(per[1]), .gaugeSyncIrq(per[0]), .vecFetch, .setIMask,
    .clearIMask, .stopWaitEnter, .irqRequest, .vectorAddr, .iMask, .sysReset);
  cpu_model core (.clk, .rst, .irqRequest, .vectorAddr, .autoFetch, .lag, .vecFetch,
    .fetchedVec, .fetchCount);
  // level build beside the edge-only one, same inputs
  external_irq_ctrl #(.LEVEL_TRIG(1)) dutLevel (.clk, .rst, .ce(1'b1), .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready(), .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready(), .s_axi_bresp(), .s_axi_bvalid(), .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready(), .s_axi_rdata(), .s_axi_rresp(), .s_axi_rvalid(),
    .s_axi_rready, .irqPinN, .portPin, .resetPinN, .portDirOut(8'h00), .portDataOut(8'h00),
    .timerStatusFlags(per[15:13]), .timerControlEnables(per[12:10]), .serialLinkIrq(per[9]),
    .serialPeriphStatusFlags(per[8:7]), .serialPeriphControlEnables(per[6:5]),
    .coreTimerOverflow(per[4]), .coreTimerOverflowEnable(per[3]), .periodicFlag(per[2]),
    .periodicInterruptEnable(per[1]), .gaugeSyncIrq(per[0]), .vecFetch, .setIMask,
    .clearIMask, .stopWaitEnter, .irqRequest(), .vectorAddr(lvlVector), .iMask(),
    .sysReset());
  initial begin
    forever #4 clk = ~clk;
  end
  task cyc(input integer n);
    repeat (n) @(posedge clk);
  endtask
  task axw(input [3:0] a, input [31:0] d);
    begin
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      @(posedge clk);
      while (s_axi_awvalid || s_axi_wvalid || s_axi_bready) begin
        if (s_axi_awready) s_axi_awvalid <= 1'b0;
        if (s_axi_wready) s_axi_wvalid <= 1'b0;
        if (s_axi_bvalid) s_axi_bready <= 1'b0;
        if (s_axi_bvalid) rsp = s_axi_bresp;
        @(posedge clk);
      end
      `CHK("bresp", (a == 4'h0 || a == 4'h4) ? 2'h0 : 2'h2, rsp)
    end
  endtask
  task rchk(input [3:0] a, input [31:0] e);
    begin
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      @(posedge clk);
      while (s_axi_rready) begin
        if (s_axi_arready) s_axi_arvalid <= 1'b0;
        if (s_axi_rvalid) s_axi_rready <= 1'b0;
        if (s_axi_rvalid) rd = s_axi_rdata;
        if (s_axi_rvalid) rsp = s_axi_rresp;
        @(posedge clk);
      end
      `CHK("rdata", e, rd)
      `CHK("rresp", (a == 4'h0 || a == 4'h4) ? 2'h0 : 2'h2, rsp)
    end
  endtask
  // k: 0 set mask, 1 clear mask, 2 stop or wait entry
  task pulse(input integer k);
    begin
      setIMask <= (k == 0);
      clearIMask <= (k == 1);
      stopWaitEnter <= (k == 2);
      @(posedge clk);
      {setIMask, clearIMask, stopWaitEnter} <= 3'b000;
      @(posedge clk);
    end
  endtask
  task t_reset;
    begin
      rchk(4'h0, 32'h80);
      rchk(4'h4, 32'h5);
      axw(4'h8, 32'h42);
      axw(4'h4, 32'h42);
      rchk(4'h8, 32'h0);
      rchk(4'h0, 32'h80);
      `CHK("sysReset", 1'b0, sysReset)
      $display("test reset done");
    end
  endtask
  task t_pin;
    begin
      axw(4'h0, 32'h8C);
      rchk(4'h0, 32'h80);
      pulse(1);
      autoFetch <= 1'b1;
      lag <= 4'h3;
      c = fetchCount;
      irqPinN <= 1'b0;
      cyc(14);
      `CHK("fetches", c + 8'h01, fetchCount)
      `CHK("vector", 16'h3FFA, fetchedVec)
      `CHK("iMask", 1'b1, iMask)
      rchk(4'h0, 32'h80);
      irqPinN <= 1'b1;
      $display("test pin done");
    end
  endtask
  task t_port;
    begin
      autoFetch <= 1'b0;
      lag <= 4'h0;
      pulse(1);
      portPin <= 8'hF7;
      cyc(6);
      rchk(4'h0, 32'h84);
      `CHK("irqRequest", 1'b0, irqRequest)
      axw(4'h0, 32'hC0);
      cyc(3);
      `CHK("irqRequest", 1'b1, irqRequest)
      `CHK("vectorAddr", 16'h3FFA, vectorAddr)
      c = fetchCount;
      autoFetch <= 1'b1;
      cyc(4);
      pulse(1);
      cyc(6);
      `CHK("fetches", c + 8'h02, fetchCount)
      autoFetch <= 1'b0;
      rchk(4'h0, 32'hC4);
      axw(4'h0, 32'hC2);
      rchk(4'h0, 32'hC0);
      portPin <= 8'hFF;
      $display("test port done");
    end
  endtask
  task t_ack;
    begin
      axw(4'h0, 32'h40);
      irqPinN <= 1'b0;
      cyc(6);
      rchk(4'h0, 32'h40);
      irqPinN <= 1'b1;
      axw(4'h0, 32'hC0);
      pulse(0);
      irqPinN <= 1'b0;
      cyc(6);
      rchk(4'h0, 32'hC8);
      `CHK("irqRequest", 1'b0, irqRequest)
      axw(4'h0, 32'hC2);
      rchk(4'h0, 32'hC0);
      `CHK("lvlVector", 16'h3FFA, lvlVector)
      `CHK("edgeVector", 16'h0000, vectorAddr)
      irqPinN <= 1'b1;
      $display("test ack done");
    end
  endtask
  task t_prio;
    begin
      pulse(1);
      for (i = 0; i < 9; i = i + 1) begin
        per <= TV[16*i +: 16];
        cyc(4);
        `CHK("vectorAddr", EV[16*i +: 16], vectorAddr)
        `CHK("irqRequest", EV[16*i +: 16] != 16'h0, irqRequest)
      end
      per <= 16'h0001;
      pulse(0);
      cyc(2);
      `CHK("irqRequest", 1'b0, irqRequest)
      per <= 16'h0000;
      $display("test priority done");
    end
  endtask
  task t_stop;
    begin
      axw(4'h0, 32'h40);
      pulse(2);
      `CHK("iMask", 1'b0, iMask)
      rchk(4'h0, 32'hC0);
      portPin <= 8'hFE;
      cyc(6);
      `CHK("irqRequest", 1'b1, irqRequest)
      axw(4'h0, 32'hC2);
      portPin <= 8'hFF;
      $display("test stop done");
    end
  endtask
  task t_rpin;
    begin
      resetPinN <= 1'b0;
      cyc(6);
      `CHK("sysReset", 1'b1, sysReset)
      resetPinN <= 1'b1;
      cyc(6);
      `CHK("sysReset", 1'b0, sysReset)
      `CHK("iMask", 1'b1, iMask)
      rchk(4'h0, 32'h80);
      $display("test reset pin done");
    end
  endtask
  task stop_test;
    begin
      $display("checks %0d errors %0d", totalChecks, errors);
      if (errors == 0 && totalChecks > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    cyc(3);
    t_reset;
    t_pin;
    t_port;
    t_ack;
    t_prio;
    t_stop;
    t_rpin;
    stop_test;
  end
  // whole run is a few hundred cycles
  initial begin
    #40000;
    errors = errors + 1;
    $display("watchdog expired");
    stop_test;
  end
endmodule
